// File: charger_protection_pkg.sv
`default_nettype none
package charger_protection_pkg;

	// ---------------------------------------------------------------
	// charge option register
	// ---------------------------------------------------------------
	localparam logic [7:0] OPT_ADDR = 8'h12;
	localparam logic [15:0] OPT_RESET = 16'h6140;
	localparam int OPT_LOWQ_BIT = 15;
	localparam int OPT_WD_MSB = 14;
	localparam int OPT_WD_LSB = 13;
	localparam int OPT_SYSTEM_OVERVOLTAGE_BIT = 11;
	localparam int OPT_FREQ_MSB = 9;
	localparam int OPT_FREQ_LSB = 8;
	localparam int OPT_INPUT_OVERCURRENT_TRIP_BIT = 7;
	localparam int OPT_LSOC_BIT = 6;

	localparam logic [1:0] WD_OFF = 2'h0;
	localparam logic [1:0] WD_SHORT = 2'h1;
	localparam logic [1:0] WD_MID = 2'h2;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_FREQ_MHZ = 200;
	localparam int MS_TICK_US = 1000;
	localparam int MS_TICK_CYCLES = MS_TICK_US * CLK_FREQ_MHZ;
	localparam int LS_BLANK_NS = 100;
	localparam int LS_BLANK_CYCLES = (LS_BLANK_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int SYSTEM_OVERVOLTAGE_DEG_US = 24;
	localparam int SYSTEM_OVERVOLTAGE_DEG_CYCLES = SYSTEM_OVERVOLTAGE_DEG_US * CLK_FREQ_MHZ;
	localparam int MS_PER_S = 1000;
	localparam int WD_SHORT_S = 44;
	localparam int WD_MID_S = 88;
	localparam int WD_LONG_S = 175;
	localparam int WD_CNT_W = 18;
	localparam int INPUT_OVERCURRENT_TRIP_RELAX_MS = 300;
	localparam int FET_CHECK_MS = 20;
	localparam int SW_CNT_W = 9;
	localparam int ADAPTER_DEG_MS = 2;
	// one extra tick covers the phase of the free-running millisecond tick
	localparam int ADAPTER_DEG_TICKS = ADAPTER_DEG_MS + 1;

	typedef enum logic [2:0] {
		SW_OFF = 3'b000,
		SW_CHECK = 3'b001,
		SW_ON = 3'b010,
		SW_RELAX = 3'b011,
		SW_FAULT = 3'b100
	} sw_state_t;

endpackage
`default_nettype wire

// File: comparator_sync.sv
`timescale 1ns/10ps
`default_nettype none
module comparator_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [W-1:0] raw,
	output logic [W-1:0] synced
);
	logic [W-1:0] stage1;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1 <= '0;
			synced <= '0;
		end
		else
		begin
			stage1 <= raw;
			synced <= stage1;
		end
	end
endmodule
`default_nettype wire

// File: rise_deglitch.sv
`timescale 1ns/10ps
`default_nettype none
// rising edge must hold for COUNT enabled cycles; falling edge passes at once
module rise_deglitch #(
	parameter int COUNT = 2
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic tick_en,
	input wire logic raw,
	output logic filt
);
	localparam int CW = $clog2(COUNT + 1);
	logic [CW-1:0] cnt;
	wire done = (cnt == CW'(COUNT - 1));

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= '0;
			filt <= 1'b0;
		end
		else if (!raw)
		begin
			cnt <= '0;
			filt <= 1'b0;
		end
		else if (!filt && tick_en)
		begin
			if (done)
				filt <= 1'b1;
			else
				cnt <= cnt + 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: charger_protection_supervisor.sv
`timescale 1ns/10ps
`default_nettype none
module charger_protection_supervisor
	import charger_protection_pkg::*;
#(
	parameter int TICK_CYCLES = MS_TICK_CYCLES,
	parameter int SYSTEM_OVERVOLTAGE_CYCLES = SYSTEM_OVERVOLTAGE_DEG_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rd_data,
	input wire logic charge_voltage_cmd,
	input wire logic charge_current_cmd,
	input wire logic vcc_above_undervoltage_lockout,
	input wire logic adapter_detect_low,
	input wire logic adapter_detect_in,
	input wire logic battery_sense_in,
	input wire logic vcc_over_adapter_ov,
	input wire logic vcc_below_recover,
	input wire logic vcc_over_battery,
	input wire logic input_overcurrent_trip,
	input wire logic peak_overcurrent,
	input wire logic low_side_overcurrent,
	input wire logic battery_overvoltage,
	input wire logic system_overvoltage,
	input wire logic thermal_hot,
	input wire logic thermal_cool,
	input wire logic gate_voltage_low,
	input wire logic low_side_gate_drive,
	input wire logic adapter_good_in,
	output logic adapter_good_out,
	output logic adapter_good_oe,
	output logic current_sense_amp_input_en,
	output logic current_sense_amp_discharge_en,
	output logic current_monitor_valid,
	output logic low_power_mode,
	output logic charge_enable,
	output logic converter_enable,
	output logic soft_start_req,
	output logic adapter_switch_en,
	output logic reverse_block_switch_en,
	output logic battery_switch_en,
	output logic discharge_sink_en,
	output logic [1:0] freq_select,
	output logic ls_oc_high_sel,
	output logic ls_oc_arm,
	output logic sense_short_sel,
	output logic high_side_block
);
	localparam int TW = $clog2(TICK_CYCLES);
	localparam int BW = $clog2(LS_BLANK_CYCLES + 1);

	function automatic logic [WD_CNT_W-1:0] wd_period(input logic [1:0] sel);
		logic [WD_CNT_W-1:0] p;
		case (sel)
			WD_SHORT: p = WD_CNT_W'(WD_SHORT_S * MS_PER_S);
			WD_MID: p = WD_CNT_W'(WD_MID_S * MS_PER_S);
			default: p = WD_CNT_W'(WD_LONG_S * MS_PER_S);
		endcase
		return p;
	endfunction

	// ---------------------------------------------------------------
	// input synchronisation
	// ---------------------------------------------------------------
	logic [14:0] cmp_sync;
	comparator_sync #(.W(15)) u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.raw({vcc_above_undervoltage_lockout, adapter_detect_low, adapter_detect_in, battery_sense_in,
			vcc_over_adapter_ov, vcc_below_recover, vcc_over_battery,
			input_overcurrent_trip, peak_overcurrent, low_side_overcurrent,
			battery_overvoltage, system_overvoltage, thermal_hot, thermal_cool,
			gate_voltage_low}),
		.synced(cmp_sync)
	);
	wire vcc_ok = cmp_sync[14];
	wire det_low = cmp_sync[13];
	wire det_2v4 = cmp_sync[12];
	wire bat_ok = cmp_sync[11];
	wire acov_s = cmp_sync[10];
	wire below24_s = cmp_sync[9];
	wire headroom_s = cmp_sync[8];
	wire inoc_s = cmp_sync[7];
	wire peak_s = cmp_sync[6];
	wire lsoc_s = cmp_sync[5];
	wire batov_s = cmp_sync[4];
	wire sysov_s = cmp_sync[3];
	wire hot_s = cmp_sync[2];
	wire cool_s = cmp_sync[1];
	wire gate_low_s = cmp_sync[0];

	// ---------------------------------------------------------------
	// millisecond tick and deglitch filters
	// ---------------------------------------------------------------
	logic [TW-1:0] tick_cnt;
	wire ms_tick = (tick_cnt == TW'(TICK_CYCLES - 1));
	logic adapter_present;
	logic sysov_deg;

	rise_deglitch #(.COUNT(ADAPTER_DEG_TICKS)) u_adapter_deg (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.tick_en(ms_tick),
		.raw(det_2v4),
		.filt(adapter_present)
	);
	rise_deglitch #(.COUNT(SYSTEM_OVERVOLTAGE_CYCLES)) u_system_overvoltage_deg (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.tick_en(1'b1),
		.raw(sysov_s),
		.filt(sysov_deg)
	);

	// ---------------------------------------------------------------
	// register access
	// ---------------------------------------------------------------
	logic [15:0] opt;
	logic system_overvoltage_latch;
	logic adapter_prev;
	wire opt_wr = reg_wr_en && (reg_addr == OPT_ADDR);
	wire [15:0] opt_view = {opt[15:12], system_overvoltage_latch, opt[10:0]};
	wire [15:0] next_rd_data = (reg_addr == OPT_ADDR) ? opt_view : 16'h0000;
	wire replug = adapter_present && !adapter_prev;
	// latch set wins over a same-cycle clear by write or replug
	wire next_system_overvoltage = sysov_deg || (system_overvoltage_latch
		&& !(opt_wr && !reg_wdata[OPT_SYSTEM_OVERVOLTAGE_BIT]) && !replug);
	wire lowq = opt[OPT_LOWQ_BIT];
	wire [1:0] wd_sel = opt[OPT_WD_MSB:OPT_WD_LSB];

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			opt <= OPT_RESET;
			system_overvoltage_latch <= 1'b0;
			adapter_prev <= 1'b0;
			tick_cnt <= '0;
		end
		else
		begin
			if (opt_wr)
				opt <= reg_wdata;
			system_overvoltage_latch <= next_system_overvoltage;
			adapter_prev <= adapter_present;
			tick_cnt <= ms_tick ? '0 : tick_cnt + 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// watchdog
	// ---------------------------------------------------------------
	logic [WD_CNT_W-1:0] wd_cnt;
	logic wd_expired;
	wire wd_kick = charge_voltage_cmd || charge_current_cmd;
	wire wd_off_wr = opt_wr && (reg_wdata[OPT_WD_MSB:OPT_WD_LSB] == WD_OFF);
	wire wd_hit = (wd_sel != WD_OFF) && (wd_cnt >= wd_period(wd_sel));

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wd_cnt <= '0;
			wd_expired <= 1'b0;
		end
		else if (wd_kick || wd_off_wr || wd_sel == WD_OFF)
		begin
			wd_cnt <= '0;
			wd_expired <= 1'b0;
		end
		else if (wd_hit)
			wd_expired <= 1'b1;
		else if (ms_tick)
			wd_cnt <= wd_cnt + 1'b1;
	end

	// ---------------------------------------------------------------
	// input switch sequencing
	// ---------------------------------------------------------------
	sw_state_t sw_state, next_state;
	logic [SW_CNT_W-1:0] sw_cnt;
	logic adapter_overvoltage;
	wire next_adapter_overvoltage = acov_s || (adapter_overvoltage && !(below24_s && det_2v4));
	wire adapter_ok = adapter_present && !adapter_overvoltage && !system_overvoltage_latch;
	wire input_overcurrent_trip_trip = opt[OPT_INPUT_OVERCURRENT_TRIP_BIT] && inoc_s;
	wire check_done = ms_tick && (sw_cnt == SW_CNT_W'(FET_CHECK_MS - 1));
	wire relax_done = ms_tick && (sw_cnt == SW_CNT_W'(INPUT_OVERCURRENT_TRIP_RELAX_MS - 1));
	wire sw_on = (sw_state == SW_CHECK) || (sw_state == SW_ON);

	always_comb
	begin
		next_state = sw_state;
		case (sw_state)
			SW_OFF:
				if (adapter_ok)
					next_state = SW_CHECK;
			SW_CHECK:
				if (!adapter_ok)
					next_state = SW_OFF;
				else if (input_overcurrent_trip_trip)
					next_state = SW_RELAX;
				else if (check_done)
					next_state = gate_low_s ? SW_FAULT : SW_ON;
			SW_ON:
				if (!adapter_ok)
					next_state = SW_OFF;
				else if (input_overcurrent_trip_trip)
					next_state = SW_RELAX;
			SW_RELAX:
				if (relax_done)
					next_state = SW_OFF;
			SW_FAULT:
				if (!adapter_present)
					next_state = SW_OFF;
			default:
				next_state = SW_OFF;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sw_state <= SW_OFF;
			sw_cnt <= '0;
			adapter_overvoltage <= 1'b0;
		end
		else
		begin
			sw_state <= next_state;
			adapter_overvoltage <= next_adapter_overvoltage;
			if (next_state != sw_state)
				sw_cnt <= '0;
			else if (ms_tick)
				sw_cnt <= sw_cnt + 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// converter protection and low-side blanking
	// ---------------------------------------------------------------
	logic thermal_off;
	logic [BW-1:0] ls_cnt;
	wire ls_armed = low_side_gate_drive && (ls_cnt == BW'(LS_BLANK_CYCLES));
	wire next_thermal = hot_s || (thermal_off && !cool_s);

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			thermal_off <= 1'b0;
			ls_cnt <= '0;
		end
		else
		begin
			thermal_off <= next_thermal;
			if (!low_side_gate_drive)
				ls_cnt <= '0;
			else if (!ls_armed)
				ls_cnt <= ls_cnt + 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// output decode
	// ---------------------------------------------------------------
	wire in_csa = !lowq && vcc_ok && det_low;
	wire dis_csa = !lowq && bat_ok;
	wire next_low_power = lowq && bat_ok && !(vcc_ok && det_low);
	wire next_charge = sw_on && !wd_expired && !thermal_off && !adapter_overvoltage;
	wire next_good = vcc_ok && !adapter_overvoltage && adapter_present && headroom_s;
	wire next_hs_block = peak_s || (ls_armed && lsoc_s);

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_rd_data <= 16'h0000;
			adapter_good_out <= 1'b0;
			adapter_good_oe <= 1'b1;
			current_sense_amp_input_en <= 1'b0;
			current_sense_amp_discharge_en <= 1'b0;
			current_monitor_valid <= 1'b0;
			low_power_mode <= 1'b0;
			charge_enable <= 1'b0;
			converter_enable <= 1'b0;
			soft_start_req <= 1'b0;
			adapter_switch_en <= 1'b0;
			reverse_block_switch_en <= 1'b0;
			battery_switch_en <= 1'b0;
			discharge_sink_en <= 1'b0;
			freq_select <= OPT_RESET[OPT_FREQ_MSB:OPT_FREQ_LSB];
			ls_oc_high_sel <= OPT_RESET[OPT_LSOC_BIT];
			ls_oc_arm <= 1'b0;
			sense_short_sel <= 1'b0;
			high_side_block <= 1'b0;
		end
		else
		begin
			reg_rd_data <= next_rd_data;
			adapter_good_out <= 1'b0;
			adapter_good_oe <= !next_good;
			current_sense_amp_input_en <= in_csa;
			current_sense_amp_discharge_en <= dis_csa;
			current_monitor_valid <= in_csa || dis_csa;
			low_power_mode <= next_low_power;
			charge_enable <= next_charge;
			converter_enable <= !system_overvoltage_latch && !thermal_off;
			soft_start_req <= thermal_off && !next_thermal;
			adapter_switch_en <= (next_state == SW_CHECK) || (next_state == SW_ON);
			reverse_block_switch_en <= (next_state == SW_CHECK) || (next_state == SW_ON);
			battery_switch_en <= !batov_s;
			discharge_sink_en <= batov_s;
			freq_select <= opt[OPT_FREQ_MSB:OPT_FREQ_LSB];
			ls_oc_high_sel <= opt[OPT_LSOC_BIT];
			ls_oc_arm <= ls_armed;
			sense_short_sel <= low_side_gate_drive && !ls_armed;
			high_side_block <= next_hs_block;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	low_power_off_a: assert property (low_power_mode |-> !current_monitor_valid)
		else $error("monitor valid in low-power mode");
	wd_suspend_a: assert property (wd_expired && !wd_kick |=> !charge_enable)
		else $error("charging while watchdog expired");
	wd_disable_a: assert property (wd_off_wr |=> !wd_expired)
		else $error("watchdog disable did not resume");
	input_overcurrent_trip_off_a: assert property (sw_state == SW_RELAX |=> !adapter_switch_en && !charge_enable)
		else $error("switches on during over-current relax");
	input_overcurrent_trip_gate_a: assert property (sw_on && next_state == SW_RELAX |-> opt[OPT_INPUT_OVERCURRENT_TRIP_BIT])
		else $error("over-current trip while disabled");
	hs_block_a: assert property (peak_s || (ls_armed && lsoc_s) |=> high_side_block)
		else $error("high side not blocked");
	blank_arm_a: assert property ($rose(low_side_gate_drive) |-> !ls_armed [*8])
		else $error("low-side check armed inside blanking");
	bat_ovp_a: assert property (batov_s |=> !battery_switch_en && discharge_sink_en)
		else $error("battery over-voltage response missing");
	system_overvoltage_read_a: assert property (system_overvoltage_latch && reg_addr == OPT_ADDR |=> reg_rd_data[11])
		else $error("latched system over-voltage not reported");
	thermal_off_a: assert property (thermal_off |=> !converter_enable)
		else $error("converter on in thermal shutdown");
	adapter_overvoltage_good_a: assert property (adapter_overvoltage |=> adapter_good_oe && !adapter_switch_en)
		else $error("adapter over-voltage not handled");
	fet_fault_a: assert property (sw_state == SW_FAULT |=> !adapter_switch_en)
		else $error("switch on after gate check failure");

	wd_expire_c: cover property (!wd_expired ##1 wd_expired);
	input_overcurrent_trip_relax_c: cover property (sw_state == SW_ON ##1 sw_state == SW_RELAX);
	fet_fault_c: cover property (sw_state == SW_CHECK ##1 sw_state == SW_FAULT);
	system_overvoltage_c: cover property ($rose(system_overvoltage_latch));
endmodule
`default_nettype wire

// File: host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// host controller: option writes and charge command pulses
// ---------------------------------------------------------------
module host_model
	import charger_protection_pkg::*;
(
	input wire logic clk_sys,
	output logic reg_wr_en,
	output logic [7:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic charge_voltage_cmd,
	output logic charge_current_cmd
);
	// idle address rests on the option register so readback needs no extra step
	initial
	begin
		reg_wr_en = 1'h0;
		reg_addr = OPT_ADDR;
		reg_wdata = 16'h0;
		charge_voltage_cmd = 1'h0;
		charge_current_cmd = 1'h0;
	end

	// a zero in bit 11 clears the over-voltage latch
	task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
		@(negedge clk_sys);
		reg_wr_en = 1'h1;
		reg_addr = addr;
		reg_wdata = data;
		@(negedge clk_sys);
		reg_wr_en = 1'h0;
		reg_addr = OPT_ADDR;
		// released data bus must not keep the last word
		reg_wdata = ~data;
	endtask

	// either command restarts the charge watchdog
	task automatic kick(input logic cur);
		@(negedge clk_sys);
		charge_current_cmd = cur;
		charge_voltage_cmd = !cur;
		@(negedge clk_sys);
		charge_current_cmd = 1'h0;
		charge_voltage_cmd = 1'h0;
	endtask
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import charger_protection_pkg::*;
;
	// ---------------------------------------------------------------
	// stimulus and observation
	// ---------------------------------------------------------------
	localparam int CHG = 0, CONV = 1, ASW = 2, RBSW = 3, BSW = 4, SINK = 5, OE = 6, GOUT = 7;
	localparam int AMPI = 8, AMPD = 9, MON = 10, LPM = 11, HSB = 12, ARM = 13, SHRT = 14;
	localparam int LSHI = 15, SS = 16, FREQ = 17, RD = 19;
	localparam logic [15:0] HI = 16'h1, LO = 16'h0;
	typedef struct {string name; int lsb; int w; logic [15:0] exp;} note_t;
	string nm [20] = '{"charge", "converter", "adapter_sw", "reverse_sw", "battery_sw", "sink",
		"good_oe", "good_out", "amp_in", "amp_dis", "monitor", "low_power", "hs_block", "ls_arm",
		"short_sel", "ls_high", "soft_start", "freq", "", "rd_data"};
	note_t q [$];
	note_t n;
	int n_errors = 0;
	int num_checks = 0;
	logic [15:0] opt = OPT_RESET;
	logic [15:0] seen;
	logic clk_sys = 1'h0;
	logic rst_n = 1'h0;
	logic reg_wr_en, charge_voltage_cmd, charge_current_cmd;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rd_data;
	logic vcc_above_undervoltage_lockout = 1'h0, adapter_detect_low = 1'h0, adapter_detect_in = 1'h0;
	logic battery_sense_in = 1'h0, vcc_over_adapter_ov = 1'h0, vcc_below_recover = 1'h0;
	logic vcc_over_battery = 1'h0, input_overcurrent_trip = 1'h0, peak_overcurrent = 1'h0;
	logic battery_overvoltage = 1'h0, system_overvoltage = 1'h0, thermal_hot = 1'h0;
	logic thermal_cool = 1'h1, low_side_gate_drive = 1'h0, adapter_good_in;
	logic low_side_overcurrent = 1'h0, gate_voltage_low = 1'h0;
	logic adapter_good_out, adapter_good_oe, current_sense_amp_input_en;
	logic current_sense_amp_discharge_en, current_monitor_valid, low_power_mode, charge_enable;
	logic converter_enable, soft_start_req, adapter_switch_en, reverse_block_switch_en;
	logic battery_switch_en, discharge_sink_en, ls_oc_high_sel, ls_oc_arm, sense_short_sel;
	logic high_side_block;
	logic [1:0] freq_select;
	logic [34:0] obs;

	// open-drain pin with pull-up
	assign adapter_good_in = adapter_good_oe ? 1'h0 : 1'h1;
	assign obs = {reg_rd_data, freq_select, soft_start_req, ls_oc_high_sel, sense_short_sel,
		ls_oc_arm, high_side_block, low_power_mode, current_monitor_valid,
		current_sense_amp_discharge_en, current_sense_amp_input_en, adapter_good_out,
		adapter_good_oe, discharge_sink_en, battery_switch_en, reverse_block_switch_en,
		adapter_switch_en, converter_enable, charge_enable};

	always #2.5 clk_sys = ~clk_sys;

	host_model host (.clk_sys, .reg_wr_en, .reg_addr, .reg_wdata, .charge_voltage_cmd,
		.charge_current_cmd);

	// short tick keeps the WD_SHORT watchdog period inside the run
	charger_protection_supervisor #(.TICK_CYCLES(2), .SYSTEM_OVERVOLTAGE_CYCLES(8)) dut (.clk_sys, .rst_n,
		.reg_wr_en, .reg_addr, .reg_wdata, .reg_rd_data, .charge_voltage_cmd, .charge_current_cmd,
		.vcc_above_undervoltage_lockout, .adapter_detect_low, .adapter_detect_in, .battery_sense_in,
		.vcc_over_adapter_ov, .vcc_below_recover, .vcc_over_battery, .input_overcurrent_trip,
		.peak_overcurrent, .low_side_overcurrent, .battery_overvoltage, .system_overvoltage,
		.thermal_hot, .thermal_cool, .gate_voltage_low, .low_side_gate_drive, .adapter_good_in,
		.adapter_good_out, .adapter_good_oe, .current_sense_amp_input_en,
		.current_sense_amp_discharge_en, .current_monitor_valid, .low_power_mode, .charge_enable,
		.converter_enable, .soft_start_req, .adapter_switch_en, .reverse_block_switch_en,
		.battery_switch_en, .discharge_sink_en, .freq_select, .ls_oc_high_sel, .ls_oc_arm,
		.sense_short_sel, .high_side_block);

	// ---------------------------------------------------------------
	// scoreboard
	// ---------------------------------------------------------------
	task automatic tally_and_finish();
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic ex(input int b, input logic [15:0] v);
		q.push_back(note_t'{nm[b], b, (b == RD) ? 16 : (b == FREQ) ? 2 : 1, v});
	endtask

	// outputs only move at the rising edge, so notes are judged mid-cycle
	initial
	forever
	begin
		wait (q.size() != 0);
		n = q.pop_front();
		seen = 16'((obs >> n.lsb) & ((35'h1 << n.w) - 35'h1));
		check(n.name, seen, n.exp);
	end

	task automatic cyc(input int k);
		repeat (k) @(negedge clk_sys);
	endtask

	task automatic await(input int b, input logic v, input int lim);
		int i;
		i = 0;
		while (obs[b] !== v && i < lim)
		begin
			@(negedge clk_sys);
			i++;
		end
		if (obs[b] !== v)
		begin
			n_errors++;
			$display("Error wait %s expected %h seen %h", nm[b], v, obs[b]);
			tally_and_finish();
		end
	endtask

	task automatic wr_opt(input logic [15:0] d);
		opt = d & 16'hF7FF;
		host.write_reg(OPT_ADDR, opt);
		cyc(2);
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial
	begin
		void'($urandom(14201));
		cyc(12);
		rst_n = 1'h1;
		cyc(3);
		ex(RD, OPT_RESET);
		ex(LSHI, HI);
		ex(OE, HI);
		ex(BSW, HI);
		ex(ASW, LO);
		ex(GOUT, LO);
		host.write_reg(8'h14, 16'hFFFF);
		cyc(2);
		ex(RD, OPT_RESET);
		for (int f = 0; f < 4; f++)
		begin
			wr_opt({opt[15:10], 2'(f), opt[7:6], 6'($urandom())});
			ex(FREQ, 16'(f));
			ex(RD, opt);
		end
		vcc_above_undervoltage_lockout = 1'h1;
		adapter_detect_low = 1'h1;
		battery_sense_in = 1'h1;
		vcc_over_battery = 1'h1;
		vcc_below_recover = 1'h1;
		cyc(4);
		ex(AMPI, HI);
		ex(AMPD, HI);
		ex(MON, HI);
		adapter_detect_in = 1'h1;
		cyc(3);
		ex(ASW, LO);
		await(ASW, 1'h1, 20);
		ex(RBSW, HI);
		ex(CHG, LO);
		await(OE, 1'h0, 20);
		ex(OE, LO);
		host.kick(1'h0);
		await(CHG, 1'h1, 60);
		ex(CONV, HI);
		peak_overcurrent = 1'h1;
		cyc(4);
		ex(HSB, HI);
		peak_overcurrent = 1'h0;
		cyc(4);
		ex(HSB, LO);
		low_side_gate_drive = 1'h1;
		cyc(10);
		ex(SHRT, HI);
		ex(ARM, LO);
		cyc(14);
		ex(ARM, HI);
		ex(SHRT, LO);
		low_side_gate_drive = 1'h0;
		cyc(2);
		ex(ARM, LO);
		wr_opt(opt & 16'hFFBF);
		ex(LSHI, LO);
		battery_overvoltage = 1'h1;
		cyc(4);
		ex(BSW, LO);
		ex(SINK, HI);
		battery_overvoltage = 1'h0;
		cyc(4);
		ex(BSW, HI);
		ex(SINK, LO);
		thermal_hot = 1'h1;
		thermal_cool = 1'h0;
		cyc(4);
		ex(CONV, LO);
		thermal_hot = 1'h0;
		cyc(6);
		ex(CONV, LO);
		thermal_cool = 1'h1;
		await(SS, 1'h1, 8);
		ex(SS, HI);
		await(CHG, 1'h1, 8);
		ex(CONV, HI);
		system_overvoltage = 1'h1;
		cyc(5);
		system_overvoltage = 1'h0;
		cyc(6);
		ex(ASW, HI);
		system_overvoltage = 1'h1;
		cyc(14);
		system_overvoltage = 1'h0;
		cyc(6);
		ex(ASW, LO);
		ex(CONV, LO);
		ex(RD, opt | 16'h0800);
		wr_opt(opt);
		ex(RD, opt);
		await(ASW, 1'h1, 20);
		await(CHG, 1'h1, 60);
		// let the gate check finish so the trip hits a settled switch
		cyc(44);
		input_overcurrent_trip = 1'h1;
		cyc(6);
		ex(ASW, HI);
		input_overcurrent_trip = 1'h0;
		wr_opt(opt | 16'h0080);
		input_overcurrent_trip = 1'h1;
		cyc(4);
		input_overcurrent_trip = 1'h0;
		ex(ASW, LO);
		ex(RBSW, LO);
		ex(CHG, LO);
		cyc(580);
		ex(ASW, LO);
		await(ASW, 1'h1, 60);
		await(CHG, 1'h1, 60);
		vcc_over_adapter_ov = 1'h1;
		vcc_below_recover = 1'h0;
		cyc(4);
		ex(OE, HI);
		ex(CHG, LO);
		ex(ASW, LO);
		ex(BSW, HI);
		vcc_over_adapter_ov = 1'h0;
		cyc(4);
		ex(ASW, LO);
		vcc_below_recover = 1'h1;
		await(ASW, 1'h1, 20);
		await(OE, 1'h0, 20);
		ex(OE, LO);
		await(CHG, 1'h1, 60);
		wr_opt({opt[15], WD_SHORT, opt[12:0]});
		cyc(2000);
		host.kick(1'h1);
		cyc(87700);
		ex(CHG, HI);
		await(CHG, 1'h0, 600);
		ex(RD, opt);
		wr_opt({opt[15], WD_OFF, opt[12:0]});
		await(CHG, 1'h1, 10);
		cyc(200);
		ex(CHG, HI);
		wr_opt(opt | 16'h8000);
		adapter_detect_in = 1'h0;
		adapter_detect_low = 1'h0;
		cyc(4);
		ex(LPM, HI);
		ex(MON, LO);
		ex(AMPI, LO);
		ex(AMPD, LO);
		ex(ASW, LO);
		ex(BSW, HI);
		system_overvoltage = 1'h1;
		cyc(14);
		system_overvoltage = 1'h0;
		cyc(4);
		ex(RD, opt | 16'h0800);
		// replug clears the latch; a stuck gate then trips the turn-on check
		gate_voltage_low = 1'h1;
		adapter_detect_low = 1'h1;
		adapter_detect_in = 1'h1;
		await(ASW, 1'h1, 30);
		ex(RD, opt);
		ex(OE, LO);
		vcc_over_battery = 1'h0;
		await(ASW, 1'h0, 60);
		ex(ASW, LO);
		ex(RBSW, LO);
		ex(OE, HI);
		cyc(10);
		ex(ASW, LO);
		cyc(1);
		tally_and_finish();
	end
endmodule
`default_nettype wire
